// file: hw/pirq_top.sv
// interrupt enable/flag registers, restore command and thermistor select
// assumes a decoded 8-bit register port from the serial slave, same clock
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - charger enable at 0x38 resets to 0; bits 7,6,5 enable peak, isothermal, watchdog.
// R2 - charger enable bits 3..0 enable thermistor, battery, mode change, input bus.
// R3 - charger enable bit 4 enables the 130 C overtemperature warning.
// R4 - charger flags at 0x39 are read-only, reset 0, same positions as enables.
// R5 - the watchdog alarm flag is set 2 s before a 32 s or 4 s before a 64 s expiry.
// R6 - every flag in both flag registers clears when its register is read.
// R7 - boost/ldo enable at 0x3A resets 0; bits 2,1,0 enable led open, boost pg, ldo1 pg.
// R8 - boost/ldo flags at 0x3B read-only, reset 0, bits 7..3 read zero.
// R9 - writing 0x7F to 0x3C returns every register to its default.
// R10 - 0x3D bit 0 picks 100k (0) or 47k (1), resets 1, used only if select setting is 1.
// R11 - the interrupt pin is active while any enabled flag is set.
module pirq_top
	import pirq_pkg::*;
#(
	parameter int CLK_HZ = 200_000_000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic coil_peak_evt_i,
	input wire logic isothermal_evt_i,
	input wire logic overtemp_evt_i,
	input wire logic thermistor_threshold_evt_i,
	input wire logic battery_threshold_evt_i,
	input wire logic charge_mode_change_evt_i,
	input wire logic input_threshold_evt_i,
	input wire logic led_open_evt_i,
	input wire logic boost_power_good_evt_i,
	input wire logic regulator1_power_good_evt_i,
	input wire logic wd_tick_i,
	input wire logic wd_kick_i,
	input wire logic wd_long_i,
	input wire logic thermistor_select_setting_i,
	output logic irq_o,
	output logic thermistor_47k_o
);
	typedef struct packed {
		logic [7:0] chg_en;
		logic [2:0] bl_en;
		logic therm_sel;
		logic [6:0] wd_sec;
		logic wd_alarm_done;
		logic [7:0] rdata;
	} pirq_top_type;
	pirq_top_type st_r;
	pirq_top_type st_nxt;

	logic [PIRQ_CHG_W-1:0] chg_flags;
	logic [PIRQ_BL_W-1:0] bl_flags;
	logic [PIRQ_CHG_W-1:0] chg_evt;
	logic [PIRQ_BL_W-1:0] bl_evt;
	logic restore;
	logic wd_alarm;
	logic [6:0] wd_period;
	logic [6:0] wd_lead;

	// R9 restore key decode
	assign restore = reg_wr_i && (reg_addr_i == PIRQ_ADDR_RESTORE)
		&& (reg_wdata_i == PIRQ_RESTORE_KEY);

	// watchdog alarm lead depends on the selected period
	assign wd_period = wd_long_i ? 7'(PIRQ_WD_LONG_S) : 7'(PIRQ_WD_SHORT_S);
	assign wd_lead = wd_long_i ? 7'(PIRQ_WD_LEAD_LONG_S)
		: 7'(PIRQ_WD_LEAD_SHORT_S);
	// R5 alarm when elapsed reaches period minus lead
	assign wd_alarm = wd_tick_i && !st_r.wd_alarm_done
		&& ((st_r.wd_sec + 7'd1) == (wd_period - wd_lead));

	// event vectors in enable bit order
	always_comb begin
		chg_evt = '0;
		chg_evt[PIRQ_BIT_COIL_PEAK] = coil_peak_evt_i;
		chg_evt[PIRQ_BIT_ISOTHERMAL] = isothermal_evt_i;
		chg_evt[PIRQ_BIT_WD_ALARM] = wd_alarm;
		chg_evt[PIRQ_BIT_OVERTEMP] = overtemp_evt_i;
		chg_evt[PIRQ_BIT_THERMISTOR] = thermistor_threshold_evt_i;
		chg_evt[PIRQ_BIT_BATTERY] = battery_threshold_evt_i;
		chg_evt[PIRQ_BIT_MODE_CHG] = charge_mode_change_evt_i;
		chg_evt[PIRQ_BIT_INPUT] = input_threshold_evt_i;
		bl_evt = '0;
		bl_evt[PIRQ_BIT_LED_OPEN] = led_open_evt_i;
		bl_evt[PIRQ_BIT_BOOST_PG] = boost_power_good_evt_i;
		bl_evt[PIRQ_BIT_REG1_PG] = regulator1_power_good_evt_i;
	end

	// R4 charger flag bank
	pirq_flag_bank #(
		.W(PIRQ_CHG_W)
	) u_chg_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.restore_i(restore),
		.rd_clr_i(reg_rd_i && (reg_addr_i == PIRQ_ADDR_CHG_FLAG)),
		.event_i(chg_evt),
		.flags_o(chg_flags)
	);

	// R8 boost/ldo flag bank
	pirq_flag_bank #(
		.W(PIRQ_BL_W)
	) u_bl_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.restore_i(restore),
		.rd_clr_i(reg_rd_i && (reg_addr_i == PIRQ_ADDR_BL_FLAG)),
		.event_i(bl_evt),
		.flags_o(bl_flags)
	);

	// register writes, read capture and watchdog seconds
	always_comb begin
		st_nxt = st_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				// R1 R2 R3 charger enables
				PIRQ_ADDR_CHG_EN: st_nxt.chg_en = reg_wdata_i;
				// R7 boost/ldo enables
				PIRQ_ADDR_BL_EN: st_nxt.bl_en = reg_wdata_i[PIRQ_BL_W-1:0];
				// R10 thermistor value bit
				PIRQ_ADDR_THERM: st_nxt.therm_sel = reg_wdata_i[0];
				default: st_nxt.rdata = st_r.rdata;
			endcase
		end
		// read data captured at the strobe; flags seen before clear
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				PIRQ_ADDR_CHG_EN: st_nxt.rdata = st_r.chg_en;
				PIRQ_ADDR_CHG_FLAG: st_nxt.rdata = chg_flags;
				PIRQ_ADDR_BL_EN: st_nxt.rdata = {5'h0, st_r.bl_en};
				PIRQ_ADDR_BL_FLAG: st_nxt.rdata = {5'h0, bl_flags};
				PIRQ_ADDR_THERM: st_nxt.rdata = {7'h0, st_r.therm_sel};
				default: st_nxt.rdata = PIRQ_ZERO8;
			endcase
		end
		// seconds since last kick; held at the selected period, wraps if the period drops below the count
		if (wd_kick_i) begin
			st_nxt.wd_sec = '0;
			st_nxt.wd_alarm_done = 1'b0;
		end else if (wd_tick_i && st_r.wd_sec != wd_period) begin
			st_nxt.wd_sec = st_r.wd_sec + 7'd1;
			if (wd_alarm) begin
				st_nxt.wd_alarm_done = 1'b1;
			end
		end
		// R9 restore all defaults, overrides the write above
		if (restore) begin
			st_nxt.chg_en = PIRQ_CHG_EN_RST;
			st_nxt.bl_en = PIRQ_BL_EN_RST;
			st_nxt.therm_sel = PIRQ_THERM_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.chg_en <= PIRQ_CHG_EN_RST;
			st_r.bl_en <= PIRQ_BL_EN_RST;
			st_r.therm_sel <= PIRQ_THERM_RST;
			st_r.wd_sec <= '0;
			st_r.wd_alarm_done <= 1'b0;
			st_r.rdata <= PIRQ_ZERO8;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o = st_r.rdata;
	// R11 enabled flags drive the pin
	assign irq_o = |(chg_flags & st_r.chg_en) | |(bl_flags & st_r.bl_en);
	// R10 47k only when the select setting allows it
	assign thermistor_47k_o = thermistor_select_setting_i & st_r.therm_sel;

	a_irq_follows_en: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == ((chg_flags & st_r.chg_en) != 0 || (bl_flags & st_r.bl_en) != 0))
		else $error("irq pin disagrees with enabled flags"); // R11
	// restore wins over same-cycle events, so both banks must read empty
	a_restore_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && restore) |=> (st_r.chg_en == PIRQ_CHG_EN_RST
		&& st_r.bl_en == PIRQ_BL_EN_RST && st_r.therm_sel == PIRQ_THERM_RST
		&& chg_flags == '0 && bl_flags == '0))
		else $error("restore did not return defaults"); // R9
	a_chg_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && reg_wr_i && reg_addr_i == PIRQ_ADDR_CHG_EN)
		|=> st_r.chg_en == $past(reg_wdata_i))
		else $error("charger enable write lost"); // R1
	a_bl_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(reg_rd_i && ce_i) && $past(reg_addr_i) == PIRQ_ADDR_BL_FLAG)
		|-> reg_rdata_o[7:3] == 5'h0)
		else $error("unused boost flag bits read nonzero"); // R8
	a_wd_alarm_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wd_alarm && !restore) |=> chg_flags[PIRQ_BIT_WD_ALARM])
		else $error("watchdog alarm flag not set"); // R5
	a_therm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!thermistor_select_setting_i |-> !thermistor_47k_o)
		else $error("thermistor select active while gated"); // R10
	a_flag_read_clr: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == PIRQ_ADDR_CHG_FLAG && chg_evt == 0)
		|=> chg_flags == 0)
		else $error("charger flags not cleared on read"); // R6
	a_flag_readback: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && reg_rd_i && reg_addr_i == PIRQ_ADDR_CHG_FLAG)
		|=> reg_rdata_o == $past(chg_flags))
		else $error("charger flag read returned wrong value"); // R4
endmodule
`default_nettype wire

// file: hw/pirq_pkg.sv
// constants for the pmic interrupt and misc register block
// assumes an 8-bit register port with 8-bit addresses
package pirq_pkg;
	localparam logic [7:0] PIRQ_ADDR_CHG_EN = 8'h38;
	localparam logic [7:0] PIRQ_ADDR_CHG_FLAG = 8'h39;
	localparam logic [7:0] PIRQ_ADDR_BL_EN = 8'h3A;
	localparam logic [7:0] PIRQ_ADDR_BL_FLAG = 8'h3B;
	localparam logic [7:0] PIRQ_ADDR_RESTORE = 8'h3C;
	localparam logic [7:0] PIRQ_ADDR_THERM = 8'h3D;
	localparam logic [7:0] PIRQ_RESTORE_KEY = 8'h7F;
	localparam logic [7:0] PIRQ_CHG_EN_RST = 8'h00;
	localparam logic [2:0] PIRQ_BL_EN_RST = 3'h0;
	localparam logic PIRQ_THERM_RST = 1'b1;
	localparam int PIRQ_CHG_W = 8;
	localparam int PIRQ_BL_W = 3;
	// charger flag bit positions
	localparam int PIRQ_BIT_COIL_PEAK = 7;
	localparam int PIRQ_BIT_ISOTHERMAL = 6;
	localparam int PIRQ_BIT_WD_ALARM = 5;
	localparam int PIRQ_BIT_OVERTEMP = 4;
	localparam int PIRQ_BIT_THERMISTOR = 3;
	localparam int PIRQ_BIT_BATTERY = 2;
	localparam int PIRQ_BIT_MODE_CHG = 1;
	localparam int PIRQ_BIT_INPUT = 0;
	// boost/ldo flag bit positions
	localparam int PIRQ_BIT_LED_OPEN = 2;
	localparam int PIRQ_BIT_BOOST_PG = 1;
	localparam int PIRQ_BIT_REG1_PG = 0;
	// watchdog periods and alarm leads, in seconds
	localparam int PIRQ_WD_SHORT_S = 32;
	localparam int PIRQ_WD_LONG_S = 64;
	localparam int PIRQ_WD_LEAD_SHORT_S = 2;
	localparam int PIRQ_WD_LEAD_LONG_S = 4;
	localparam logic [7:0] PIRQ_ZERO8 = 8'h00;
endpackage

// file: hw/pirq_flag_bank.sv
// one bank of sticky event flags, cleared on read of the bank
// assumes events are synchronous, one clk pulses or levels
`timescale 1ns/10ps
`default_nettype none
module pirq_flag_bank #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic restore_i,
	input wire logic rd_clr_i,
	input wire logic [W-1:0] event_i,
	output logic [W-1:0] flags_o
);
	typedef struct packed {
		logic [W-1:0] flags;
	} pirq_fb_type;
	pirq_fb_type st_r;
	pirq_fb_type st_nxt;

	// set wins over clear-on-read so no event is lost
	always_comb begin
		st_nxt = st_r;
		if (restore_i) begin
			st_nxt.flags = '0;
		end else begin
			// R6 clear on read
			if (rd_clr_i) begin
				st_nxt.flags = '0;
			end
			st_nxt.flags = st_nxt.flags | event_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign flags_o = st_r.flags;

	a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !restore_i && rd_clr_i) |=> (st_r.flags == $past(event_i)))
		else $error("flag clear lost a same-cycle event"); // R6
endmodule
`default_nettype wire

// file: tb/pirq_host.sv
// host model: single-cycle register strobes into the block
// assumes strobes taken at a rising edge, read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module pirq_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	// idle bus at time zero
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'hFF;
		wdata_o = 8'hFF;
	end
	// host register write
	// one write, held across exactly one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a; // released bus shows no stale value
		wdata_o = ~d;
	endtask
	// one read; data is taken at the falling edge half a cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// file: tb/pirq_top_tb.sv
// bench for the interrupt and misc register block
// assumes the host model drives the register port on falling edges
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
	err_total++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module pirq_top_tb;
	import pirq_pkg::*;
	logic clk, rst, ce, wr, rd, tick, kick, wlong, tsel, irq, t47;
	logic [7:0] addr, wdata, rdata, cev, got;
	logic [2:0] bev;
	int err_total, n_checks, cyc, i;
	pirq_top pirq_top_inst (.clk_i(clk), .rst_i(rst), .ce_i(ce),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.coil_peak_evt_i(cev[7]), .isothermal_evt_i(cev[6]),
		.overtemp_evt_i(cev[4]), .thermistor_threshold_evt_i(cev[3]),
		.battery_threshold_evt_i(cev[2]),
		.charge_mode_change_evt_i(cev[1]), .input_threshold_evt_i(cev[0]),
		.led_open_evt_i(bev[2]), .boost_power_good_evt_i(bev[1]),
		.regulator1_power_good_evt_i(bev[0]), .wd_tick_i(tick),
		.wd_kick_i(kick), .wd_long_i(wlong),
		.thermistor_select_setting_i(tsel), .irq_o(irq),
		.thermistor_47k_o(t47));
	pirq_host pirq_host_inst (.clk_i(clk), .rdata_i(rdata), .wr_o(wr),
		.rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		pirq_host_inst.rd(a, got);
		`CHK($sformatf("reg_%h", a), e, got)
	endtask
	// events high for one cycle
	task automatic pulse(input logic [7:0] c, input logic [2:0] b);
		@(negedge clk);
		cev = c;
		bev = b;
		@(negedge clk);
		cev = 8'h00;
		bev = 3'h0;
	endtask
	task automatic tk(input int n);
		repeat (n) begin
			@(negedge clk);
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
		end
	endtask
	// alarm must come exactly at period minus lead
	task automatic wdog(input logic lng, input int n);
		wlong = lng;
		@(negedge clk);
		kick = 1'b1;
		@(negedge clk);
		kick = 1'b0;
		tk(n - 1);
		chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h00);
		tk(1);
		`CHK("irq", 1'b1, irq)
		chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h20);
	endtask
	initial begin
		{tick, kick, wlong, cev, bev} = '0;
		ce = 1'b1;
		tsel = 1'b1;
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		// defaults, write-only and unmapped places
		chk_rd(PIRQ_ADDR_CHG_EN, 8'h00);
		chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h00);
		chk_rd(PIRQ_ADDR_BL_EN, 8'h00);
		chk_rd(PIRQ_ADDR_BL_FLAG, 8'h00);
		chk_rd(PIRQ_ADDR_RESTORE, 8'h00);
		chk_rd(PIRQ_ADDR_THERM, 8'h01);
		chk_rd(8'h40, 8'h00);
		`CHK("t47", 1'b1, t47)
		$display("test reset done");
		// all others masked off, then each source alone; watchdog alarm left to its own test
		for (i = 0; i < 8; i++) begin
			if (i == PIRQ_BIT_WD_ALARM) continue;
			pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'h01 << i);
			chk_rd(PIRQ_ADDR_CHG_EN, 8'h01 << i);
			pulse(~(8'h01 << i), 3'h7);
			`CHK("irq", 1'b0, irq)
			pulse(8'h01 << i, 3'h0);
			`CHK("irq", 1'b1, irq)
			chk_rd(PIRQ_ADDR_CHG_FLAG, 8'hDF);
			`CHK("irq", 1'b0, irq)
			chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h00);
			chk_rd(PIRQ_ADDR_BL_FLAG, 8'h07);
		end
		pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'h00);
		for (i = 0; i < 3; i++) begin
			pirq_host_inst.wr(PIRQ_ADDR_BL_EN, 8'hF8 | (8'h01 << i));
			chk_rd(PIRQ_ADDR_BL_EN, 8'h01 << i);
			pulse(8'hFF, ~(3'h1 << i));
			`CHK("irq", 1'b0, irq)
			pulse(8'h00, 3'h1 << i);
			`CHK("irq", 1'b1, irq)
			chk_rd(PIRQ_ADDR_BL_FLAG, 8'h07);
			`CHK("irq", 1'b0, irq)
			chk_rd(PIRQ_ADDR_CHG_FLAG, 8'hDF);
		end
		$display("test sources done");
		pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'h20);
		wdog(1'b0, PIRQ_WD_SHORT_S - PIRQ_WD_LEAD_SHORT_S);
		wdog(1'b1, PIRQ_WD_LONG_S - PIRQ_WD_LEAD_LONG_S);
		$display("test watchdog done");
		// refused writes, frozen clock enable, then restore
		pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'hFF);
		pirq_host_inst.wr(PIRQ_ADDR_BL_EN, 8'h07);
		pirq_host_inst.wr(PIRQ_ADDR_THERM, 8'h00);
		@(negedge clk);
		`CHK("t47", 1'b0, t47)
		pirq_host_inst.wr(PIRQ_ADDR_CHG_FLAG, 8'hFF);
		chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h00);
		pirq_host_inst.wr(PIRQ_ADDR_RESTORE, 8'h7E);
		chk_rd(PIRQ_ADDR_CHG_EN, 8'hFF);
		ce = 1'b0;
		pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'h00);
		ce = 1'b1;
		chk_rd(PIRQ_ADDR_CHG_EN, 8'hFF);
		pulse(8'h80, 3'h4);
		`CHK("irq", 1'b1, irq)
		pirq_host_inst.wr(PIRQ_ADDR_RESTORE, PIRQ_RESTORE_KEY);
		`CHK("irq", 1'b0, irq)
		chk_rd(PIRQ_ADDR_CHG_EN, 8'h00);
		chk_rd(PIRQ_ADDR_BL_EN, 8'h00);
		chk_rd(PIRQ_ADDR_BL_FLAG, 8'h00);
		chk_rd(PIRQ_ADDR_THERM, 8'h01);
		`CHK("t47", 1'b1, t47)
		tsel = 1'b0;
		@(negedge clk);
		`CHK("t47", 1'b0, t47)
		$display("test restore done");
		// mid-run reset with live flags and enables
		pirq_host_inst.wr(PIRQ_ADDR_CHG_EN, 8'hFF);
		pirq_host_inst.wr(PIRQ_ADDR_THERM, 8'h00);
		pulse(8'hFF, 3'h7);
		`CHK("irq", 1'b1, irq)
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		`CHK("irq", 1'b0, irq)
		tsel = 1'b1;
		chk_rd(PIRQ_ADDR_CHG_EN, 8'h00);
		chk_rd(PIRQ_ADDR_CHG_FLAG, 8'h00);
		chk_rd(PIRQ_ADDR_BL_FLAG, 8'h00);
		chk_rd(PIRQ_ADDR_THERM, 8'h01);
		`CHK("t47", 1'b1, t47)
		$display("test mid reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
